// ### rtl/acq_trigger_bank.sv
// Acquisition trigger and LED delay register bank with frame sequencing.
`timescale 1ns/10ps
`default_nettype none
`include "acq_trigger_params.svh"
module acq_trigger_bank (
	// System clock and asynchronous active-low reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// Host register port: one strobe per transfer, read answer a cycle late.
	input wire logic [7:0] regAddr,
	input wire acq_trigger_pkg::byte_t regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output acq_trigger_pkg::byte_t regRdata,
	output logic regRvalid,
	// Acquisition core side: status, frame end and the delay-path switch.
	input wire logic dataReady,
	input wire logic [5:0] readoutBytes,
	input wire logic frameDone,
	input wire logic delayPathConfigBit,
	// Sequencer outputs and the effective LED delay-line step codes.
	output logic acqStart,
	output logic acqActive,
	output logic [9:0] ledFineSteps,
	output logic [5:0] ledCoarseSteps
);
	import acq_trigger_pkg::*;

	// Host-visible register contents.
	byte_t trigger_ff;
	byte_t fineLo_ff;
	byte_t fineHi_ff;
	byte_t coarse_ff;
	// Read answer, held until the next read strobe.
	byte_t rdata_ff;
	logic rvalid_ff;
	// Frame sequencer state, its registered outputs and next values.
	logic start_ff;
	logic active_ff;
	acq_state_t state_ff;
	acq_state_t nxt_state;
	logic nxt_start;
	logic autoClear;

	// Fine count bits above the low byte, and the coarse count width.
	localparam int FineHiBits = `FINE_DELAY_BITS - $bits(byte_t);
	localparam int CoarseBits = `COARSE_DELAY_BITS;

	led_delay_if dly ();

	// True when a write strobe targets the given location.
	// Reads never disturb register contents, so only writes are decoded.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] loc);
		hit = regWrite && (a == loc);
	endfunction

	// Only the two documented trigger bits are kept; the rest read zero.
	// Dropping the reserved bits at write time keeps the read path simple.
	function automatic byte_t trigMask(input byte_t d);
		trigMask = 8'h00;
		trigMask[`BIT_SHUTTER_RELEASE] = d[`BIT_SHUTTER_RELEASE];
		trigMask[`BIT_MULTI_FRAME] = d[`BIT_MULTI_FRAME];
	endfunction

	// Frame sequencer: a frame starts when the shutter bit is set and the
	// core is idle; at frame end it restarts only in multi-frame mode.
	// Trigger changes made while a frame runs are only looked at when the
	// core reports the frame end, so a host write can never cut a frame
	// short. The cost is that clearing the trigger lets the running frame
	// finish before the run flag drops.
	always_comb begin
		nxt_state = state_ff;
		nxt_start = 1'b0;
		autoClear = 1'b0;
		unique case (state_ff)
			ACQ_IDLE: begin
				if (trigger_ff[`BIT_SHUTTER_RELEASE]) begin
					nxt_state = ACQ_RUN;
					nxt_start = 1'b1;
					autoClear = !trigger_ff[`BIT_MULTI_FRAME];
				end
			end
			ACQ_RUN: begin
				if (frameDone) begin
					if (trigger_ff[`BIT_SHUTTER_RELEASE] &&
						trigger_ff[`BIT_MULTI_FRAME]) begin
						nxt_start = 1'b1;
					end else begin
						nxt_state = ACQ_IDLE;
					end
				end
			end
		endcase
	end

	// Sequencer state and the one-cycle start pulse. The start pulse is
	// registered so that the acquisition core sees a clean single-cycle
	// request one clock after the sequencer decides to start.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ACQ_IDLE;
			start_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			start_ff <= nxt_start;
		end
	end

	// Trigger register. A host write in the same cycle as the auto-clear
	// wins, so a fresh trigger from software is never dropped. Only the
	// shutter bit is ever cleared by hardware; the multi-frame select is
	// owned by the host alone and keeps whatever was last written.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			trigger_ff <= `RST_TRIGGER_CTRL;
		end else if (hit(regAddr, `ADDR_TRIGGER_CTRL)) begin
			trigger_ff <= trigMask(regWdata);
		end else if (autoClear) begin
			trigger_ff[`BIT_SHUTTER_RELEASE] <= 1'b0;
		end
	end

	// Delay setting registers; the host keeps the counts in range. Each
	// byte lands as soon as it is written, with no staging, so a host that
	// changes the fine count while the delay path is on will see the new
	// low byte applied one write before the new high byte.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fineLo_ff <= `RST_FINE_DELAY_LO;
			fineHi_ff <= `RST_FINE_DELAY_HI;
			coarse_ff <= `RST_COARSE_DELAY;
		end else begin
			if (hit(regAddr, `ADDR_FINE_DELAY_LO)) begin
				fineLo_ff <= regWdata;
			end
			if (hit(regAddr, `ADDR_FINE_DELAY_HI)) begin
				fineHi_ff <= regWdata;
			end
			if (hit(regAddr, `ADDR_COARSE_DELAY)) begin
				coarse_ff <= regWdata;
			end
		end
	end

	// Fine count joins the two bytes; unused upper bits are not applied,
	// which relies on the host staying within the supported maximum.
	// The stored upper bits still read back exactly as written.
	assign dly.fineSteps = {fineHi_ff[FineHiBits-1:0], fineLo_ff};
	assign dly.coarseSteps = coarse_ff[CoarseBits-1:0];
	assign dly.pathEnable = delayPathConfigBit;

	// The stage gates the settings with the delay-path switch and holds
	// the codes in flops, so the delay line only ever sees settled values
	// and a path switched off shows zero steps from the next clock edge on.
	led_delay_stage delayStage (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.dly(dly)
	);

	// Read decode. Locations that hold nothing answer with zero, so a
	// stray host read never picks up the contents of another register.
	// The status byte is built live from the core's pins at the strobe.
	function automatic byte_t readMux(input logic [7:0] a);
		unique case (a)
			`ADDR_READOUT_STATUS:
				readMux = {dataReady, 1'b0, readoutBytes};
			`ADDR_TRIGGER_CTRL: readMux = trigger_ff;
			`ADDR_FINE_DELAY_LO: readMux = fineLo_ff;
			`ADDR_FINE_DELAY_HI: readMux = fineHi_ff;
			`ADDR_COARSE_DELAY: readMux = coarse_ff;
			default: readMux = `READ_UNMAPPED;
		endcase
	endfunction

	// Read port: the answer is registered and stands one cycle after the
	// strobe. This costs a cycle of latency but keeps the address decode
	// out of the path that the host samples.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= `READ_UNMAPPED;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= regRead;
			if (regRead) begin
				rdata_ff <= readMux(regAddr);
			end
		end
	end

	// Run flag in its own flop, loaded from the next state, so the output
	// comes straight from a register and carries no decode glitches. It
	// tracks the sequencer state exactly, cycle for cycle.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			active_ff <= 1'b0;
		end else begin
			active_ff <= (nxt_state == ACQ_RUN);
		end
	end

	// Output drivers; every data output comes straight from a register,
	// so the host and the core never see combinational decode glitches.
	assign regRdata = rdata_ff;
	assign regRvalid = rvalid_ff;
	assign acqStart = start_ff;
	assign acqActive = active_ff;
	assign ledFineSteps = dly.effFineSteps;
	assign ledCoarseSteps = dly.effCoarseSteps;
endmodule // acq_trigger_bank
`default_nettype wire

// ### rtl/acq_trigger_params.svh
// Register locations, field positions and reset values of the trigger block.
`ifndef ACQ_TRIGGER_PARAMS_SVH
`define ACQ_TRIGGER_PARAMS_SVH

`define ADDR_READOUT_STATUS 8'h55
`define ADDR_TRIGGER_CTRL 8'h58
`define ADDR_FINE_DELAY_LO 8'h71
`define ADDR_FINE_DELAY_HI 8'h72
`define ADDR_COARSE_DELAY 8'h73

`define BIT_DATA_READY 7
`define BIT_SHUTTER_RELEASE 0
`define BIT_MULTI_FRAME 1
`define BIT_DELAY_PATH_EN 2

`define RST_TRIGGER_CTRL 8'h00
`define RST_FINE_DELAY_LO 8'h00
`define RST_FINE_DELAY_HI 8'h00
`define RST_COARSE_DELAY 8'h00
`define READ_UNMAPPED 8'h00

`define FINE_DELAY_BITS 10
`define COARSE_DELAY_BITS 6
`define FINE_DELAY_MAX 10'h31F
`define COARSE_DELAY_MAX 6'h31
`define FINE_STEP_PS 10
`define COARSE_STEP_NS 2

`endif

// ### rtl/acq_trigger_pkg.sv
// Types shared by the trigger block files.
package acq_trigger_pkg;
	typedef logic [7:0] byte_t;

	typedef enum logic [0:0] {
		ACQ_IDLE = 1'b0,
		ACQ_RUN = 1'b1
	} acq_state_t;
endpackage

// ### rtl/led_delay_if.sv
// Carrier between the register bank and the LED delay settings stage.
`timescale 1ns/10ps
`default_nettype none
interface led_delay_if;
	logic [9:0] fineSteps;
	logic [5:0] coarseSteps;
	logic pathEnable;
	logic [9:0] effFineSteps;
	logic [5:0] effCoarseSteps;

	modport bank (output fineSteps, output coarseSteps, output pathEnable,
		input effFineSteps, input effCoarseSteps);
	modport stage (input fineSteps, input coarseSteps, input pathEnable,
		output effFineSteps, output effCoarseSteps);
endinterface
`default_nettype wire

// ### rtl/led_delay_stage.sv
// Registers the effective LED delay-line step codes.
`timescale 1ns/10ps
`default_nettype none
`include "acq_trigger_params.svh"
module led_delay_stage (
	input wire logic sys_clk,
	input wire logic reset_n,
	led_delay_if.stage dly
);
	import acq_trigger_pkg::*;

	logic [9:0] effFine_ff;
	logic [5:0] effCoarse_ff;

	// Settings only reach the delay line while the path is enabled, so a
	// half-programmed value cannot disturb the LED while it is off.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			effFine_ff <= 10'h000;
			effCoarse_ff <= 6'h00;
		end else if (dly.pathEnable) begin
			effFine_ff <= dly.fineSteps;
			effCoarse_ff <= dly.coarseSteps;
		end else begin
			effFine_ff <= 10'h000;
			effCoarse_ff <= 6'h00;
		end
	end

	assign dly.effFineSteps = effFine_ff;
	assign dly.effCoarseSteps = effCoarse_ff;
endmodule // led_delay_stage
`default_nettype wire

// ### test/acq_trigger_bank_assertions.sv
// Port checker for the trigger and LED delay register bank.
`timescale 1ns/10ps
`default_nettype none
module acq_trigger_bank_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] regAddr,
	input wire acq_trigger_pkg::byte_t regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire acq_trigger_pkg::byte_t regRdata,
	input wire logic regRvalid,
	input wire logic dataReady,
	input wire logic [5:0] readoutBytes,
	input wire logic frameDone,
	input wire logic delayPathConfigBit,
	input wire logic acqStart,
	input wire logic acqActive,
	input wire logic [9:0] ledFineSteps,
	input wire logic [5:0] ledCoarseSteps
);
	import acq_trigger_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// A write seen through two more cycles with the delay path kept on.
	sequence s_wr(a);
		regWrite && regAddr == a && delayPathConfigBit ##1
			delayPathConfigBit [*2];
	endsequence
	AST_STATUS: assert property (regRead && regAddr == 8'h55 |=>
		regRvalid && regRdata == {$past(dataReady), 1'b0, $past(readoutBytes)})
		else $error("status read wrong");
	AST_TRIG_RD: assert property (regRead && regAddr == 8'h58 |=>
		regRdata[7:2] == 6'h00) else $error("trigger reserved bits set");
	AST_SINGLE: assert property (regWrite && regAddr == 8'h58 &&
		regWdata[0] && !acqActive |=> ##1 acqStart) else $error("no start");
	AST_ROSE: assert property ($rose(acqActive) |-> acqStart)
		else $error("run without start");
	AST_RESTART: assert property (acqActive && frameDone |=>
		acqStart || !acqActive) else $error("frame end not handled");
	AST_GATE_OFF: assert property (!delayPathConfigBit &&
		!$past(delayPathConfigBit) |-> ledFineSteps == 10'h000 &&
		ledCoarseSteps == 6'h00) else $error("delay applied while off");
	AST_FINE_LO: assert property (s_wr(8'h71) |->
		ledFineSteps[7:0] == $past(regWdata, 2)) else $error("fine low");
	AST_FINE_HI: assert property (s_wr(8'h72) |->
		ledFineSteps[9:8] == $past(regWdata[1:0], 2)) else $error("fine high");
	AST_COARSE: assert property (s_wr(8'h73) |->
		ledCoarseSteps == $past(regWdata[5:0], 2)) else $error("coarse");
endmodule // acq_trigger_bank_checker
bind acq_trigger_bank acq_trigger_bank_checker i_chk (.*);
`default_nettype wire

// ### test/frame_core_model.sv
// Behavioural acquisition core: ends each frame after a set latency.
`timescale 1ns/10ps
`default_nettype none
module frame_core_model (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic acqStart,
	input wire logic [3:0] lat,
	output logic frameDone,
	output logic dataReady
);
	logic [4:0] cnt_ff;
	// Data stays ready until the next frame starts, as a real core would.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= 5'h00;
			frameDone <= 1'b0;
			dataReady <= 1'b0;
		end else begin
			frameDone <= cnt_ff == 5'h01;
			if (cnt_ff == 5'h01)
				dataReady <= 1'b1;
			if (acqStart) begin
				cnt_ff <= {1'b0, lat} + 5'h02;
				dataReady <= 1'b0;
			end else if (cnt_ff != 5'h00)
				cnt_ff <= cnt_ff - 5'h01;
		end
	end
endmodule // frame_core_model
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the trigger and LED delay register bank.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import acq_trigger_pkg::*;
	logic sys_clk, reset_n, regWrite, regRead, regRvalid, dataReady;
	logic frameDone, delayPathConfigBit, acqStart, acqActive;
	logic [7:0] regAddr, expq[$];
	logic [7:0] regs[5] = '{8'h58, 8'h71, 8'h72, 8'h73, 8'h10};
	byte_t regWdata, regRdata, hi, crs;
	logic [5:0] readoutBytes, ledCoarseSteps;
	logic [9:0] ledFineSteps, fine;
	logic [3:0] lat;
	int error_cnt, comparisons, starts, cyc;
	acq_trigger_bank i_dut (.*);
	frame_core_model i_core (.*);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic chk(input string n, input logic [9:0] e, g);
		comparisons++;
		if (e !== g)
			$display("ERROR %s exp %0h got %0h", n, e, g);
		if (e !== g)
			error_cnt++;
	endtask
	// Byte answers and single flags get compare tasks of their own width.
	task automatic chk_rd(input string n, input logic [7:0] e, g);
		comparisons++;
		if (e !== g) begin
			$display("ERROR %s exp %0h got %0h", n, e, g);
			error_cnt++;
		end
	endtask
	task automatic chk_bit(input string n, input logic e, g);
		comparisons++;
		if (e !== g) begin
			$display("ERROR %s exp %0h got %0h", n, e, g);
			error_cnt++;
		end
	endtask
	task automatic acc(input int w, input logic [7:0] a, d);
		@(posedge sys_clk);
		#2;
		{regAddr, regWdata, regWrite, regRead} = {a, d, w != 0, w == 0};
		@(posedge sys_clk);
		#2;
		{regWrite, regRead} = 2'b00;
	endtask
	task automatic rd(input logic [7:0] a, e);
		expq.push_back(e);
		acc(0, a, 8'h00);
	endtask
	task automatic complete_run;
		if (error_cnt == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Answers are matched to the oldest note; a hang ends the run.
	always @(posedge sys_clk) begin
		cyc++;
		if (regRvalid === 1'b1)
			chk_rd("regRdata", expq.pop_front(), regRdata);
		if (acqStart === 1'b1)
			starts++;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run();
		end
	end
	// Reset, register defaults, delay codes, then single and multi frames.
	initial begin
		{reset_n, regWrite, regRead, delayPathConfigBit, lat} = 8'h00;
		{regAddr, regWdata, readoutBytes} = 22'h000000;
		void'($urandom(59));
		repeat (4) @(posedge sys_clk);
		#2 reset_n = 1;
		readoutBytes = 6'($urandom);
		rd(8'h55, {2'b00, readoutBytes});
		foreach (regs[i]) rd(regs[i], 8'h00);
		repeat (4) begin
			fine = 10'($urandom % 800);
			crs = 8'($urandom % 50);
			hi = {6'($urandom), fine[9:8]};
			delayPathConfigBit = 1'b1;
			acc(1, 8'h71, fine[7:0]);
			acc(1, 8'h72, hi);
			acc(1, 8'h73, crs);
			rd(8'h72, hi);
			chk("ledFineSteps", fine, ledFineSteps);
			chk("ledCoarseSteps", {4'h0, crs[5:0]},
				{4'h0, ledCoarseSteps});
			delayPathConfigBit = 1'b0;
			@(posedge sys_clk);
			#2 chk("ledFineSteps", 10'h000, ledFineSteps);
			chk("ledCoarseSteps", 10'h000, {4'h0, ledCoarseSteps});
		end
		lat = 4'($urandom);
		acc(1, 8'h58, 8'hFD);
		repeat (30) @(posedge sys_clk);
		chk("starts", 10'h001, 10'(starts));
		rd(8'h58, 8'h00);
		rd(8'h55, {2'b10, readoutBytes});
		acc(1, 8'h58, 8'h03);
		repeat (60) @(posedge sys_clk);
		rd(8'h58, 8'h03);
		chk_bit("restarts", 1'b1, starts > 3);
		acc(1, 8'h58, 8'h02);
		repeat (30) @(posedge sys_clk);
		chk_bit("acqActive", 1'b0, acqActive);
		chk("pendingReads", 10'h000, 10'(expq.size()));
		complete_run();
	end
endmodule // tb
`default_nettype wire
